// *** bench/pnsram_chk.sv ***
// Port-level assertions for the memory port, bound to its top.
`timescale 1ns/1ps
module pnsram_chk #(
  parameter int DATA_W = 36
) (
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              load_advance_n,
  input wire logic              read_write_n,
  input wire logic              chip_select_n,
  input wire logic              chip_select_secondary_n,
  input wire logic              chip_select_high,
  input wire logic              clock_enable_n,
  input wire logic              output_enable_n,
  input wire logic              snooze_request,
  input wire logic [DATA_W-1:0] data_out_ff,
  input wire logic              data_oe_ff
);
  logic [3:0] calmCnt;
  logic [3:0] oeOffCnt;
  logic [3:0] snzCnt;
  logic       sel;
  logic       calm;
  logic       ld;

  assign sel  = chip_select_high && !chip_select_n && !chip_select_secondary_n;
  assign calm = !clock_enable_n && !snooze_request && !output_enable_n;
  assign ld   = !load_advance_n && calm && calmCnt > 4'h5;

  // Run lengths saturate; the input synchronisers need quiet edges before timing is exact.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      calmCnt  <= 4'h0;
      oeOffCnt <= 4'h0;
      snzCnt   <= 4'h0;
    end
    else
    begin
      calmCnt  <= calm ? calmCnt + {3'h0, calmCnt != 4'hF} : 4'h0;
      oeOffCnt <= output_enable_n ? oeOffCnt + {3'h0, oeOffCnt != 4'hF} : 4'h0;
      snzCnt   <= snooze_request ? snzCnt + {3'h0, snzCnt != 4'hF} : 4'h0;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  AST_READ_LAT: assert property (ld && read_write_n && sel ##1 calm [*3] |-> ##2 data_oe_ff)
    else $error("read slot missing");
  AST_NO_READ: assert property (ld && !(read_write_n && sel) ##1 calm [*3] |-> ##2 !data_oe_ff)
    else $error("output on write or deselect slot");
  AST_BURST: assert property (ld && read_write_n && sel ##1 (load_advance_n && calm) [*4] |-> ##1 data_oe_ff ##1 data_oe_ff)
    else $error("burst read slot missing");
  AST_DESEL_ADV: assert property (ld && !sel ##1 (load_advance_n && calm) [*4] |-> ##2 !data_oe_ff)
    else $error("advance after deselect drove data");
  AST_OE_OFF: assert property (oeOffCnt > 4'h4 |-> !data_oe_ff)
    else $error("pins driven with output disabled");
  AST_RESET_OUT: assert property ($fell(sys_rst) |-> !data_oe_ff && data_out_ff == {DATA_W{1'b0}})
    else $error("outputs not cleared by reset");
  AST_FREEZE: assert property (clock_enable_n |=> $stable(data_out_ff))
    else $error("output moved while clock disabled");
  AST_SNOOZE: assert property (snzCnt > 4'h5 |-> $stable(data_out_ff) && $stable(data_oe_ff))
    else $error("output moved in standby");
endmodule

bind pnsram_core pnsram_chk #(.DATA_W(DATA_W)) pnsram_chk_i (
  .clk_sys, .sys_rst, .load_advance_n, .read_write_n, .chip_select_n, .chip_select_secondary_n,
  .chip_select_high, .clock_enable_n, .output_enable_n, .snooze_request, .data_out_ff, .data_oe_ff
);

// *** bench/pnsram_core_test.sv ***
// Self-checking bench for the memory port.
`timescale 1ns/1ps
module pnsram_core_test;
  localparam int         AW  = 8;
  localparam int         DW  = 36;
  localparam int         LN  = 4;
  localparam int         LW  = DW / LN;
  localparam logic [2:0] SEL = 3'h4;

  logic          clk_sys;
  logic          sys_rst;
  logic [AW-1:0] word_address;
  logic          load_advance_n;
  logic          read_write_n;
  logic          chip_select_n;
  logic          chip_select_secondary_n;
  logic          chip_select_high;
  logic          clock_enable_n;
  logic [LN-1:0] byte_lane_write_n;
  logic          burst_order_sel;
  logic          output_enable_n;
  logic          snooze_request;
  logic [DW-1:0] data_in;
  logic [DW-1:0] data_out_ff;
  logic          data_oe_ff;
  logic [DW-1:0] refMem [2**AW];
  logic [DW-1:0] expQ [$];
  logic [AW-1:0] base;
  logic [1:0]    step;
  logic [1:0]    kind;
  logic          ckeSeen;
  logic          oeOff;
  int            errors;
  int            n_checks;

  pnsram_core #(.ADDR_W(AW), .DATA_W(DW), .LANES(LN), .LINEAR_LVL(1'h0)) pnsram_core_i (
    .clk_sys, .sys_rst, .word_address, .load_advance_n, .read_write_n, .chip_select_n,
    .chip_select_secondary_n, .chip_select_high, .clock_enable_n, .byte_lane_write_n,
    .burst_order_sel, .output_enable_n, .snooze_request, .data_in, .data_out_ff, .data_oe_ff
  );
  pnsram_host #(.AW(AW), .DW(DW), .LN(LN)) pnsram_host_i (
    .clk_sys, .word_address, .load_advance_n, .read_write_n, .chip_select_n,
    .chip_select_secondary_n, .chip_select_high, .clock_enable_n, .byte_lane_write_n, .data_in
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One bus cycle; the reference array is updated as each load or advance is issued because writes are coherent.
  task automatic op(input logic ld, input logic rw, input logic [AW-1:0] a, input logic [LN-1:0] bw,
                    input logic [2:0] cs, input logic [DW-1:0] d);
    logic [AW-1:0] ea;
    if (!ld)
    begin
      base = a;
      step = 2'h0;
      kind = cs != SEL ? 2'h0 : (rw ? 2'h1 : 2'h2);
    end
    else
      step = step + 2'h1;
    ea = {base[AW-1:2], burst_order_sel ? base[1:0] ^ step : base[1:0] + step};
    for (int i = 0; i < LN; i++)
      if (kind == 2'h2 && !bw[i])
        refMem[ea][i*LW +: LW] = d[i*LW +: LW];
    if (kind == 2'h1 && !oeOff)
      expQ.push_back(refMem[ea]);
    pnsram_host_i.cyc(ld, rw, a, bw, cs, d);
  endtask

  always @(posedge clk_sys)
  begin
    #1;
    if (!ckeSeen && data_oe_ff === 1'b1)
      if (expQ.size() == 0)
        chk(DW'(0), DW'(1));
      else
        chk(data_out_ff, expQ.pop_front());
    ckeSeen = clock_enable_n;
  end

  task automatic drain();
    repeat (6) op(1'b0, 1'b1, '0, '0, 3'h0, '0);
    chk(DW'(expQ.size()), DW'(0));
  endtask

  task automatic t_rw();
    for (int i = 0; i < 8; i++)
    begin
      op(1'b0, 1'b0, AW'(i * 4), '0, SEL, {4{9'(i * 37 + 5)}});
      op(1'b0, 1'b1, AW'(i * 4), '1, SEL, '0);
    end
    for (int i = 0; i < 8; i++)
      op(1'b0, 1'b1, AW'(i * 4), '0, SEL, '0);
    drain();
  endtask

  task automatic t_lanes();
    op(1'b0, 1'b0, 8'h40, '0, SEL, 36'h123456789);
    for (int i = 0; i < LN; i++)
    begin
      op(1'b0, 1'b0, 8'h40, ~LN'(1 << i), SEL, {4{9'(i + 1)}});
      op(1'b0, 1'b1, 8'h40, '1, SEL, '0);
    end
    drain();
  endtask

  // Advances carry a foreign address and false selects, which must not matter.
  task automatic t_burst();
    for (int m = 0; m < 2; m++)
    begin
      burst_order_sel = m[0];
      for (int s = 0; s < 4; s++)
      begin
        op(1'b0, 1'b0, AW'(8'h80 + s), '0, SEL, DW'(m * 64 + s * 8));
        for (int k = 1; k < 4; k++)
          op(1'b1, 1'b1, 8'hFF, '0, 3'h3, DW'(m * 64 + s * 8 + k));
        op(1'b0, 1'b1, AW'(8'h80 + s), '0, SEL, '0);
        repeat (4) op(1'b1, 1'b0, 8'hFF, '0, 3'h3, '0);
      end
      drain();
    end
  endtask

  task automatic t_desel();
    op(1'b0, 1'b0, 8'h20, '0, SEL, 36'h5A5A5A5A5);
    for (int i = 0; i < 3; i++)
    begin
      op(1'b0, 1'b0, 8'h20, '0, SEL ^ 3'(1 << i), '0);
      repeat (4) op(1'b1, 1'b0, 8'h20, '0, SEL, '0);
      op(1'b0, 1'b1, 8'h20, '0, SEL ^ 3'(1 << i), '0);
    end
    op(1'b0, 1'b1, 8'h20, '0, SEL, '0);
    drain();
  endtask

  task automatic t_cke();
    burst_order_sel = 1'b0;
    op(1'b0, 1'b1, 8'h80, '0, SEL, '0);
    op(1'b1, 1'b1, 8'hFF, '0, SEL, '0);
    pnsram_host_i.hold(3);
    repeat (2) op(1'b1, 1'b1, 8'hFF, '0, SEL, '0);
    drain();
  endtask

  task automatic t_oe();
    output_enable_n = 1'b1;
    drain();
    oeOff = 1'b1;
    op(1'b0, 1'b1, 8'h40, '0, SEL, '0);
    op(1'b0, 1'b1, 8'h20, '0, SEL, '0);
    drain();
    oeOff = 1'b0;
    output_enable_n = 1'b0;
    drain();
  endtask

  task automatic t_snooze();
    snooze_request = 1'b1;
    drain();
    repeat (4) pnsram_host_i.cyc(1'b0, 1'b0, 8'h40, '0, SEL, '0);
    drain();
    snooze_request = 1'b0;
    drain();
    op(1'b0, 1'b1, 8'h40, '0, SEL, '0);
    op(1'b0, 1'b1, 8'h20, '0, SEL, '0);
    drain();
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    errors++;
    close_out();
  end

  initial
  begin
    {errors, n_checks} = '0;
    {sys_rst, burst_order_sel, output_enable_n, snooze_request, oeOff, ckeSeen} = 6'h21;
    {base, step, kind} = '0;
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
    drain();
    t_rw();
    t_lanes();
    t_burst();
    t_desel();
    t_cke();
    t_oe();
    t_snooze();
    close_out();
  end
endmodule

// *** bench/pnsram_host.sv ***
// Host controller model driving the memory pins.
`timescale 1ns/1ps
module pnsram_host #(
  parameter int AW = 8,
  parameter int DW = 36,
  parameter int LN = 4
) (
  input  wire logic     clk_sys,
  output logic [AW-1:0] word_address,
  output logic          load_advance_n,
  output logic          read_write_n,
  output logic          chip_select_n,
  output logic          chip_select_secondary_n,
  output logic          chip_select_high,
  output logic          clock_enable_n,
  output logic [LN-1:0] byte_lane_write_n,
  output logic [DW-1:0] data_in
);
  logic [DW-1:0] wdPipe [2];
  logic          wdVal  [2];
  logic          wrType;

  initial
  begin
    {load_advance_n, read_write_n, chip_select_high, chip_select_secondary_n, chip_select_n} = 5'h01;
    word_address = '0;
    clock_enable_n = 1'b0;
    byte_lane_write_n = '0;
    data_in = '0;
    wdVal = '{1'b0, 1'b0};
    wrType = 1'b0;
  end

  // Pins move at the falling edge; write data trails its address by two enabled edges.
  task automatic cyc(input logic ld, input logic rw, input logic [AW-1:0] a, input logic [LN-1:0] bw,
                     input logic [2:0] cs, input logic [DW-1:0] d);
    @(negedge clk_sys);
    load_advance_n = ld;
    read_write_n = rw;
    word_address = a;
    byte_lane_write_n = bw;
    {chip_select_high, chip_select_secondary_n, chip_select_n} = cs;
    clock_enable_n = 1'b0;
    if (!ld)
      wrType = cs == 3'h4 && !rw;
    data_in = wdVal[1] ? wdPipe[1] : ~data_in;
    wdVal[1] = wdVal[0];
    wdPipe[1] = wdPipe[0];
    wdVal[0] = wrType;
    wdPipe[0] = d;
  endtask

  // Suspended edges carry a would-be write load that must be ignored.
  task automatic hold(input int n);
    repeat (n)
    begin
      @(negedge clk_sys);
      clock_enable_n = 1'b1;
      {load_advance_n, read_write_n} = 2'h0;
      word_address = ~word_address;
      data_in = ~data_in;
    end
  endtask
endmodule

// *** rtl/pnsram_array.sv ***
// Storage array with per-lane writes and registered read data.
`timescale 1ns/1ps
module pnsram_array #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 36,
  parameter int LANES  = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              wrEn,
  input  wire logic [LANES-1:0]  laneWr,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic              rdEn,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData_ff
);
  localparam int LW = DATA_W / LANES;

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // One byte lane per enable; a word update may touch one to four lanes.
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (wrEn && laneWr[i])
      begin
        mem[wrAddr][i*LW +: LW] <= wrData[i*LW +: LW];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rdEn)
    begin
      rdData_ff <= mem[rdAddr];
    end
  end
endmodule

// *** rtl/pnsram_burst.sv ***
// Two-bit burst address generator in linear or interleaved order.
`timescale 1ns/1ps
module pnsram_burst #(
  parameter int   BURST_W    = 2,
  parameter logic LINEAR_LVL = 1'h0
) (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic               step,
  input  wire logic               load,
  input  wire logic [BURST_W-1:0] seed,
  input  wire logic               modeSel,
  output logic      [BURST_W-1:0] lowAddr
);
  logic [BURST_W-1:0] seed_ff;
  logic [BURST_W-1:0] cnt_ff;
  logic [BURST_W-1:0] nxt_cnt;

  assign nxt_cnt = load ? '0 : BURST_W'(cnt_ff + 1'b1);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      seed_ff <= '0;
      cnt_ff  <= '0;
    end
    else if (load)
    begin
      seed_ff <= seed;
      cnt_ff  <= '0;
    end
    else if (step)
    begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Modulo arithmetic keeps the burst inside its four-word group.
  always_comb
  begin
    if (modeSel == LINEAR_LVL)
    begin
      lowAddr = BURST_W'(seed_ff + cnt_ff);
    end
    else
    begin
      lowAddr = seed_ff ^ cnt_ff;
    end
  end
endmodule

// *** rtl/pnsram_core.sv ***
// Top of the pipelined no-turnaround synchronous static memory port.
`timescale 1ns/1ps
`include "pnsram_params.svh"
module pnsram_core #(
  parameter int   ADDR_W     = `PNSRAM_ADDR_W,
  parameter int   DATA_W     = `PNSRAM_DATA_W,
  parameter int   LANES      = `PNSRAM_LANES,
  parameter logic LINEAR_LVL = `PNSRAM_MODE_LINEAR_LVL
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] word_address,
  input  wire logic              load_advance_n,
  input  wire logic              read_write_n,
  input  wire logic              chip_select_n,
  input  wire logic              chip_select_secondary_n,
  input  wire logic              chip_select_high,
  input  wire logic              clock_enable_n,
  input  wire logic [LANES-1:0]  byte_lane_write_n,
  input  wire logic              burst_order_sel,
  input  wire logic              output_enable_n,
  input  wire logic              snooze_request,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out_ff,
  output logic                   data_oe_ff
);
  localparam int BW = `PNSRAM_BURST_W;

  // --------------------------------------------------------------------
  // Input capture
  // --------------------------------------------------------------------
  // Synchronous pins come from the controller on this clock; one register
  // stage each. Output enable and snooze are asynchronous pins and pass
  // a three-stage synchroniser.
  logic [ADDR_W-1:0] addr_ff;
  logic              ldN_ff;
  logic              rwN_ff;
  logic              selOk_ff;
  logic              ckeN_ff;
  logic [LANES-1:0]  bwN_ff;
  logic [DATA_W-1:0] din_ff;
  logic              modeSel_ff;
  logic [2:0]        oeSync_ff;
  logic [2:0]        zzSync_ff;
  logic              oeN_ff;
  logic              zz_ff;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      addr_ff    <= '0;
      ldN_ff     <= 1'h1;
      rwN_ff     <= 1'h1;
      selOk_ff   <= 1'h0;
      ckeN_ff    <= 1'h1;
      bwN_ff     <= '1;
      din_ff     <= '0;
      modeSel_ff <= 1'h0;
    end
    else
    begin
      addr_ff    <= word_address;
      ldN_ff     <= load_advance_n;
      rwN_ff     <= read_write_n;
      selOk_ff   <= !chip_select_n && !chip_select_secondary_n && chip_select_high;
      ckeN_ff    <= clock_enable_n;
      bwN_ff     <= byte_lane_write_n;
      din_ff     <= data_in;
      modeSel_ff <= burst_order_sel;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      oeSync_ff <= 3'h7;
      zzSync_ff <= 3'h0;
      oeN_ff    <= 1'h1;
      zz_ff     <= 1'h0;
    end
    else
    begin
      oeSync_ff <= {oeSync_ff[1:0], output_enable_n};
      zzSync_ff <= {zzSync_ff[1:0], snooze_request};
      if (oeSync_ff[1] == oeSync_ff[2])
      begin
        oeN_ff <= oeSync_ff[2];
      end
      if (zzSync_ff[1] == zzSync_ff[2])
      begin
        zz_ff <= zzSync_ff[2];
      end
    end
  end

  // --------------------------------------------------------------------
  // Cycle decode
  // --------------------------------------------------------------------
  // Snooze and a high clock enable both freeze every pipeline stage.
  logic run;
  logic loadEdge;
  logic advEdge;
  assign run      = !ckeN_ff && !zz_ff;
  assign loadEdge = run && !ldN_ff;
  assign advEdge  = run && ldN_ff;

  pnsram_pkg::pnsram_cyc_t kind_ff;
  logic [ADDR_W-1:0]       base_ff;
  logic [LANES-1:0]        laneWr_ff;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      kind_ff   <= pnsram_pkg::PNSRAM_IDLE;
      base_ff   <= '0;
      laneWr_ff <= '0;
    end
    else if (loadEdge)
    begin
      // Selects and read/write are looked at only here.
      if (!selOk_ff)
      begin
        kind_ff <= pnsram_pkg::PNSRAM_IDLE;
      end
      else if (rwN_ff)
      begin
        kind_ff <= pnsram_pkg::PNSRAM_READ;
      end
      else
      begin
        kind_ff <= pnsram_pkg::PNSRAM_WRITE;
      end
      base_ff   <= addr_ff;
      laneWr_ff <= ~bwN_ff;
    end
  end

  // --------------------------------------------------------------------
  // Burst address
  // --------------------------------------------------------------------
  logic [BW-1:0] lowAddr;

  pnsram_burst #(
    .BURST_W    (BW),
    .LINEAR_LVL (LINEAR_LVL)
  ) u_burst (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .step    (advEdge),
    .load    (loadEdge),
    .seed    (addr_ff[BW-1:0]),
    .modeSel (modeSel_ff),
    .lowAddr (lowAddr)
  );

  // Stage 0 is the operation whose address is current after the last edge.
  pnsram_pkg::pnsram_op_t stage0;
  pnsram_pkg::pnsram_op_t stage1_ff;
  pnsram_pkg::pnsram_op_t stage2_ff;
  logic                   stage0Vld_ff;
  logic [DATA_W-1:0]      din2_ff;

  // The carrier's address field is fixed; a narrower core zero-extends into it.
  localparam int OP_AW = $bits(stage0.addr);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      stage0Vld_ff <= 1'h0;
    end
    else if (loadEdge)
    begin
      stage0Vld_ff <= 1'h1;
    end
  end

  always_comb
  begin
    stage0.kind   = stage0Vld_ff ? kind_ff : pnsram_pkg::PNSRAM_IDLE;
    stage0.addr   = OP_AW'({base_ff[ADDR_W-1:BW], lowAddr});
    stage0.laneWr = laneWr_ff;
  end

  // --------------------------------------------------------------------
  // Pipeline
  // --------------------------------------------------------------------
  // Each edge that runs moves one access along, whatever its kind, so
  // reads and writes interleave freely with no dead slot.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      stage1_ff <= '{pnsram_pkg::PNSRAM_IDLE, '0, '0};
      stage2_ff <= '{pnsram_pkg::PNSRAM_IDLE, '0, '0};
      din2_ff   <= '0;
    end
    else if (run)
    begin
      stage1_ff <= stage0;
      stage2_ff <= stage1_ff;
      // Data taken at the second enabled edge after the address moves along
      // with its write, so a late data word never lands under the wrong access.
      din2_ff   <= din_ff;
    end
  end

  // The write in stage 2 meets its data, captured two edges after its
  // address, and lands in the array on this edge.
  logic wrNow;
  assign wrNow = run && stage2_ff.kind == pnsram_pkg::PNSRAM_WRITE;

  // Read in stage 1 sees array contents without the write landing now, so
  // the pending write one stage ahead must be forwarded.
  logic [DATA_W-1:0] arrData;
  logic              rdNow;
  assign rdNow = run && stage1_ff.kind == pnsram_pkg::PNSRAM_READ;

  pnsram_array #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W),
    .LANES  (LANES)
  ) u_array (
    .clk_sys   (clk_sys),
    .wrEn      (wrNow),
    .laneWr    (stage2_ff.laneWr),
    .wrAddr    (stage2_ff.addr[ADDR_W-1:0]),
    .wrData    (din2_ff),
    .rdEn      (rdNow),
    .rdAddr    (stage1_ff.addr[ADDR_W-1:0]),
    .rdData_ff (arrData)
  );

  // Forwarding: remember lanes of the write that committed with the read.
  localparam int LW = DATA_W / LANES;
  logic [DATA_W-1:0] fwdData_ff;
  logic [LANES-1:0]  fwdLane_ff;
  logic              rdPend_ff;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fwdData_ff <= '0;
      fwdLane_ff <= '0;
      rdPend_ff  <= 1'h0;
    end
    else if (run)
    begin
      rdPend_ff  <= rdNow;
      fwdData_ff <= din2_ff;
      if (wrNow && stage2_ff.addr == stage1_ff.addr)
      begin
        fwdLane_ff <= stage2_ff.laneWr;
      end
      else
      begin
        fwdLane_ff <= '0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Output register
  // --------------------------------------------------------------------
  // The enable stays registered so the port holds no combinational path;
  // it costs the synchroniser delay on output enable.
  logic [DATA_W-1:0] merged;
  always_comb
  begin
    merged = arrData;
    for (int i = 0; i < LANES; i++)
    begin
      if (fwdLane_ff[i])
      begin
        merged[i*LW +: LW] = fwdData_ff[i*LW +: LW];
      end
    end
  end

  logic rdOut_ff;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      data_out_ff <= '0;
      rdOut_ff    <= 1'h0;
    end
    else if (run)
    begin
      rdOut_ff <= rdPend_ff;
      if (rdPend_ff)
      begin
        data_out_ff <= merged;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      data_oe_ff <= 1'h0;
    end
    else
    begin
      data_oe_ff <= (run ? rdPend_ff : rdOut_ff) && !oeN_ff && !zz_ff;
    end
  end

  // The data word width picks the organisation: 18 or 36 bits carry one
  // check bit per lane, 32 bits carry none.
endmodule

// *** rtl/pnsram_params.svh ***
// Constants for the pipelined no-turnaround synchronous static memory.
//
// Contract
// - All synchronous inputs registered on rising edge.
// - Cycles start only when load/advance is low.
// - Cycle type decoded only at load edges.
// - Two-bit burst counter makes low address bits.
// - Burst wraps within its four-address group.
// - Advance edge uses internal address, keeps type.
// - Static select picks interleaved or linear order.
// - Write data captured two edges after address.
// - Each byte enable gates one data lane.
// - Back-to-back reads and writes, no turnaround.
// - Read data registered, driven while output enabled.
// - Output enable acts asynchronously on drivers; here it is synchronised and registered first.
// - Snooze input asynchronous, active high.
// - Clock enable low runs, high suspends.
// - Three chip selects, all must be true.
// - Self-timed writes; pending write data forwarded.
// - Core 256Kx18 or 128Kx32/36 by parameter.
// - Parity bits only in 18 and 36 widths.
// - Chip selects sampled only at load edges.
// - Clock enable high freezes all state; here the input registers and synchronisers keep sampling.
// - Snooze keeps array, ignores other inputs.
// - Loaded low address bits seed burst counter.
`ifndef PNSRAM_PARAMS_SVH
`define PNSRAM_PARAMS_SVH

`define PNSRAM_ADDR_W 18
`define PNSRAM_DATA_W 18
`define PNSRAM_LANES 4
`define PNSRAM_BURST_W 2
`define PNSRAM_WR_LAG 2
`define PNSRAM_MODE_LINEAR_LVL 1'h0

`endif

// *** rtl/pnsram_pkg.sv ***
// Types shared by the memory port files.
package pnsram_pkg;

  typedef enum logic [1:0] {
    PNSRAM_IDLE,
    PNSRAM_READ,
    PNSRAM_WRITE
  } pnsram_cyc_t;

  typedef struct packed {
    pnsram_cyc_t kind;
    logic [17:0] addr;
    logic [3:0]  laneWr;
  } pnsram_op_t;

endpackage
